// ---- src/rsb_ctrl.v ----
`timescale 1ns/10ps
`include "rsb_defines.vh"
module rsb_ctrl (
   input  wire                    core_clk,          // Core clock, 50 MHz
   input  wire                    nrst,              // Master reset, sync, active low
   input  wire                    soft_reset,        // Software reset pulse
   input  wire                    terminal_enable,   // Terminal enabled
   input  wire                    broadcast_invalidate, // Address 31 not valid
   input  wire                    irq_broadcast_flag_enable,  // Global broadcast irq enable
   input  wire                    irq_access_enable, // Global accessed irq enable
   input  wire [`RSB_SA_W-1:0]    rt_address,        // Own terminal address
   input  wire                    host_wr,           // Host write strobe
   input  wire                    host_rd,           // Host read strobe
   input  wire [`RSB_SA_W-1:0]    host_sa,           // Host subaddress
   input  wire [`RSB_WORD_W-1:0]  host_wdata,        // Host write data
   output reg  [`RSB_WORD_W-1:0]  host_rdata,        // Host read data
   output reg                     host_rvalid,       // Read data valid pulse
   input  wire                    msg_start,         // Receive command pulse
   input  wire [`RSB_SA_W-1:0]    msg_rt,            // Command terminal address
   input  wire [`RSB_SA_W-1:0]    msg_sa,            // Command subaddress
   input  wire                    msg_end,           // Message complete pulse
   input  wire                    msg_ok,            // Message error free
   input  wire                    msg_busy_global,   // Busy applied globally
   output reg                     msg_accept,        // Command taken
   output reg                     msg_cfg_valid,     // Mode and buffer valid
   output wire [1:0]              msg_mode,          // Buffer mode
   output reg                     msg_buffer_b,      // 1: buffer B, 0: buffer A
   output reg                     msg_store_off,     // Busy: do not store data
   output reg                     interrupt_out      // Interrupt pulse
);
   localparam [1:0] ST_IDLE = 2'h0;
   localparam [1:0] ST_READ = 2'h1;
   localparam [1:0] ST_DEC  = 2'h2;
   localparam [1:0] ST_ACT  = 2'h3;

   reg  [1:0]              state;
   reg  [1:0]              next_state;
   reg  [`RSB_SA_W-1:0]    cur_sa;
   reg                     cur_broadcast_flag;
   reg  [`RSB_WORD_W-1:0]  cur_word;
   reg                     cur_toggle;

   reg  [`RSB_SA_N-1:0]    pp_en;
   reg  [`RSB_SA_N-1:0]    pp_stop;
   reg  [`RSB_SA_N-1:0]    pp_ack;
   reg  [`RSB_SA_N-1:0]    broadcast_flag;
   reg  [`RSB_SA_N-1:0]    dsel;
   reg  [`RSB_SA_N-1:0]    dbac;

   reg                     rd_p1;
   reg  [5:0]              rd_stat;
   reg  [`RSB_WORD_W-1:0]  next_rdata;

   wire [`RSB_WORD_W-1:0]  mem_ra;
   wire [`RSB_WORD_W-1:0]  mem_rb;
   wire                    cmd_own;
   wire                    cmd_bc;
   wire                    take;
   wire                    done;
   wire                    busy_now;
   genvar g;

   assign cmd_own = (msg_rt == rt_address);
   assign cmd_bc  = (msg_rt == `RSB_BROADCAST_FLAG_ADDR) && !broadcast_invalidate;
   // A command in a soft reset cycle is dropped, else its accept would announce a message that never runs
   assign take    = (state == ST_IDLE) && msg_start && terminal_enable && (cmd_own || cmd_bc) && !soft_reset;
   assign done    = (state == ST_ACT) && msg_end;
   assign busy_now = cur_word[`RSB_B_BUSY] || msg_busy_global;

   rsb_word_mem u_mem (
      .core_clk (core_clk),
      .nrst     (nrst),
      .wr_en    (host_wr),
      .wr_sa    (host_sa),
      .wr_data  (host_wdata & `RSB_HOST_MASK),
      .ra_sa    (host_sa),
      .ra_data  (mem_ra),
      .rb_sa    (msg_sa),
      .rb_data  (mem_rb)
   );

   rsb_mode_dec u_dec (
      .core_clk (core_clk),
      .nrst     (nrst),
      .load     (state == ST_READ),
      .pp_en    (pp_en[cur_sa]),
      .circ_b   (mem_rb[`RSB_B_CIR_B]),
      .circ_a   (mem_rb[`RSB_B_CIR_A]),
      .mode     (msg_mode)
   );

   always @* begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (take) begin
               next_state = ST_READ;
            end
         end
         ST_READ: next_state = ST_DEC;
         ST_DEC:  next_state = ST_ACT;
         ST_ACT: begin
            if (msg_end) begin
               next_state = ST_IDLE;
            end
         end
         default: next_state = ST_IDLE;
      endcase
   end

   always @(posedge core_clk) begin
      if (!nrst || soft_reset) begin
         state <= ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // Message context; the word read is held so host writes mid-message do not bite
   always @(posedge core_clk) begin
      if (!nrst) begin
         cur_sa        <= {`RSB_SA_W{1'b0}};
         cur_broadcast_flag     <= 1'b0;
         cur_word      <= `RSB_WORD_RESET;
         cur_toggle    <= 1'b0;
         msg_accept    <= 1'b0;
         msg_cfg_valid <= 1'b0;
         msg_buffer_b  <= 1'b0;
         msg_store_off <= 1'b0;
         interrupt_out <= 1'b0;
      end else begin
         msg_accept    <= take;
         interrupt_out <= 1'b0;
         if (take) begin
            cur_sa    <= msg_sa;
            cur_broadcast_flag <= cmd_bc && !cmd_own;
         end
         if (state == ST_READ) begin
            cur_word     <= mem_rb;
            msg_buffer_b <= dsel[cur_sa];
            // Enabled without ack: overwrite the selected buffer, never toggle
            cur_toggle   <= pp_en[cur_sa] && pp_ack[cur_sa];
         end
         if (state == ST_DEC) begin
            msg_cfg_valid <= 1'b1;
            msg_store_off <= busy_now;
         end
         if (done || soft_reset) begin
            msg_cfg_valid <= 1'b0;
            msg_store_off <= 1'b0;
         end
         if (done && !soft_reset) begin
            interrupt_out <= (cur_broadcast_flag && cur_word[`RSB_B_IBR] && irq_broadcast_flag_enable) ||
                             (cur_word[`RSB_B_IWA] && irq_access_enable);
         end
      end
   end

   // Per-subaddress host-written enable and stop, and device-owned state
   generate
      for (g = 0; g < `RSB_SA_N; g = g + 1) begin : g_sa
         wire wr_here   = host_wr && (host_sa == g);
         wire rd_here   = host_rd && (host_sa == g);
         wire end_here  = done && (cur_sa == g);
         wire in_msg    = (state != ST_IDLE) && (cur_sa == g);

         always @(posedge core_clk) begin
            if (!nrst) begin
               pp_en[g]   <= 1'b0;
               pp_stop[g] <= 1'b0;
            end else if (wr_here) begin
               pp_en[g]   <= host_wdata[`RSB_B_PINGPONG_ENABLE];
               pp_stop[g] <= host_wdata[`RSB_B_STOP];
            end
         end

         // Ack is never written by the host and only moves while its subaddress has no message in progress
         always @(posedge core_clk) begin
            if (!nrst) begin
               pp_ack[g] <= 1'b0;
            end else if (!in_msg) begin
               if (!pp_en[g] || pp_stop[g]) begin
                  pp_ack[g] <= 1'b0;
               end else if (terminal_enable) begin
                  pp_ack[g] <= 1'b1;
               end
            end
         end

         // Reset takes priority over a broadcast completing in the same cycle
         always @(posedge core_clk) begin
            if (!nrst || soft_reset) begin
               broadcast_flag[g] <= 1'b0;
            end else if (end_here && cur_broadcast_flag) begin
               broadcast_flag[g] <= 1'b1;
            end
         end

         always @(posedge core_clk) begin
            if (!nrst || soft_reset) begin
               dsel[g] <= 1'b0;
            end else if (end_here && cur_toggle && msg_ok && !busy_now) begin
               dsel[g] <= ~dsel[g];
            end
         end

         // Completion wins over a read clear in the same cycle
         always @(posedge core_clk) begin
            if (!nrst || soft_reset) begin
               dbac[g] <= 1'b0;
            end else if (end_here) begin
               dbac[g] <= 1'b1;
            end else if (rd_here) begin
               dbac[g] <= 1'b0;
            end
         end
      end
   endgenerate

   // Other bits come from the store; enable, stop and device-owned bits from the snapshot at the strobe
   always @* begin
      next_rdata                = mem_ra;
      next_rdata[`RSB_B_PINGPONG_ENABLE]   = rd_stat[0];
      next_rdata[`RSB_B_STOP]   = rd_stat[1];
      next_rdata[`RSB_B_PPACK]  = rd_stat[2];
      next_rdata[`RSB_B_BROADCAST_FLAG]  = rd_stat[3];
      next_rdata[`RSB_B_DSEL]   = rd_stat[4];
      next_rdata[`RSB_B_DBAC]   = rd_stat[5];
   end

   // Host read: status and memory word both taken at the strobe, read data out one cycle later
   always @(posedge core_clk) begin
      if (!nrst) begin
         rd_p1       <= 1'b0;
         rd_stat     <= 6'h00;
         host_rdata  <= `RSB_WORD_RESET;
         host_rvalid <= 1'b0;
      end else begin
         rd_p1     <= host_rd;
         if (host_rd) begin
            rd_stat <= {dbac[host_sa], dsel[host_sa], broadcast_flag[host_sa],
                        pp_ack[host_sa], pp_stop[host_sa], pp_en[host_sa]};
         end
         host_rvalid <= rd_p1;
         if (rd_p1) begin
            host_rdata <= next_rdata;
         end
      end
   end
endmodule // rsb_ctrl

// ---- src/rsb_defines.vh ----
// Notes on behaviour
// - Valid broadcast receive sets broadcast_flag of subaddress
// - Broadcast interrupt needs per-subaddress and global enable
// - broadcast_invalidate makes address 31 commands invalid
// - Master or soft reset clears broadcast_flag
// - Host writes never change pingpong_ack
// - Device raises pingpong_ack once ping-pong is active
// - Stop request set: device drops pingpong_ack
// - Stop request cleared: device raises pingpong_ack again
// - Enable without ack: use selected buffer, no toggle
// - Mode decode: ping-pong, circular B, circular A, indexed
// - Ping-pong selects A/B, toggles after good message
`ifndef RSB_DEFINES_VH
`define RSB_DEFINES_VH
`define RSB_SA_W         5
`define RSB_SA_N         32
`define RSB_WORD_W       16
`define RSB_BROADCAST_FLAG_ADDR   5'h1F
// Control word bit positions
`define RSB_B_CIR_A      0
`define RSB_B_CIR_B      1
`define RSB_B_PINGPONG_ENABLE       2
`define RSB_B_STOP       3
`define RSB_B_ZN_LO      4
`define RSB_B_ZN_HI      7
`define RSB_B_PPACK      8
`define RSB_B_BROADCAST_FLAG      9
`define RSB_B_DSEL       10
`define RSB_B_DBAC       11
`define RSB_B_BUSY       12
`define RSB_B_IBR        13
`define RSB_B_IWA        14
`define RSB_B_IXEQZ      15
// Bits the host may store; 8..11 belong to the device
`define RSB_HOST_MASK    16'hF0FF
`define RSB_WORD_RESET   16'h0000
// Buffer modes
`define RSB_MODE_INDEX   2'h0
`define RSB_MODE_CIRC_A  2'h1
`define RSB_MODE_CIRC_B  2'h2
`define RSB_MODE_PP      2'h3
`endif

// ---- src/rsb_word_mem.v ----
`timescale 1ns/10ps
`include "rsb_defines.vh"
module rsb_word_mem (
   input  wire                    core_clk,  // Core clock
   input  wire                    nrst,      // Sync reset, active low
   input  wire                    wr_en,     // Host write strobe
   input  wire [`RSB_SA_W-1:0]    wr_sa,     // Write subaddress
   input  wire [`RSB_WORD_W-1:0]  wr_data,   // Masked write data
   input  wire [`RSB_SA_W-1:0]    ra_sa,     // Host read subaddress
   output reg  [`RSB_WORD_W-1:0]  ra_data,   // Host read data, registered
   input  wire [`RSB_SA_W-1:0]    rb_sa,     // Message read subaddress
   output reg  [`RSB_WORD_W-1:0]  rb_data    // Message read data, registered
);
   reg [`RSB_WORD_W-1:0] mem [0:`RSB_SA_N-1];
   reg [`RSB_SA_N-1:0]   written;
   genvar g;

   // Entry flags give a cleared map after reset without sweeping the array
   generate
      for (g = 0; g < `RSB_SA_N; g = g + 1) begin : g_ent
         always @(posedge core_clk) begin
            if (!nrst) begin
               written[g] <= 1'b0;
            end else if (wr_en && wr_sa == g) begin
               written[g] <= 1'b1;
            end
         end
      end
   endgenerate

   always @(posedge core_clk) begin
      if (wr_en) begin
         mem[wr_sa] <= wr_data;
      end
   end

   always @(posedge core_clk) begin
      if (!nrst) begin
         ra_data <= `RSB_WORD_RESET;
         rb_data <= `RSB_WORD_RESET;
      end else begin
         ra_data <= written[ra_sa] ? mem[ra_sa] : `RSB_WORD_RESET;
         rb_data <= written[rb_sa] ? mem[rb_sa] : `RSB_WORD_RESET;
      end
   end
endmodule // rsb_word_mem

// ---- src/rsb_mode_dec.v ----
`timescale 1ns/10ps
`include "rsb_defines.vh"
module rsb_mode_dec (
   input  wire       core_clk,  // Core clock
   input  wire       nrst,      // Sync reset, active low
   input  wire       load,      // Capture strobe
   input  wire       pp_en,     // pingpong_enable
   input  wire       circ_b,    // circ_mode_b_enable
   input  wire       circ_a,    // circ_mode_a_enable
   output reg  [1:0] mode       // Decoded buffer mode
);
   always @(posedge core_clk) begin
      if (!nrst) begin
         mode <= `RSB_MODE_INDEX;
      end else if (load) begin
         if (pp_en) begin
            mode <= `RSB_MODE_PP;
         end else if (circ_b) begin
            mode <= `RSB_MODE_CIRC_B;
         end else if (circ_a) begin
            mode <= `RSB_MODE_CIRC_A;
         end else begin
            mode <= `RSB_MODE_INDEX;
         end
      end
   end
endmodule // rsb_mode_dec

// ---- test/rsb_ctrl_monitor.sv ----
`timescale 1ns/10ps
module rsb_ctrl_monitor (
   input wire       core_clk,             // Clock
   input wire       nrst,                 // Reset
   input wire       soft_reset,           // Soft reset
   input wire       terminal_enable,      // Enable
   input wire       broadcast_invalidate, // No address 31
   input wire       irq_broadcast_flag_enable,     // Irq enable
   input wire       irq_access_enable,    // Irq enable
   input wire [4:0] rt_address,           // Own address
   input wire       msg_start,            // Command
   input wire [4:0] msg_rt,               // Command address
   input wire       msg_end,              // Completion
   input wire       msg_accept,           // Taken
   input wire       msg_cfg_valid,        // Config valid
   input wire [1:0] msg_mode,             // Mode
   input wire       msg_buffer_b,         // Buffer B
   input wire       interrupt_out         // Interrupt
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!nrst);
   wire addr_ok = terminal_enable && (msg_rt == rt_address || (msg_rt == 5'h1F && !broadcast_invalidate));
   accept_cause_a: assert property (msg_accept |-> $past(msg_start && addr_ok))
      else $error("accept without valid command");
   broadcast_flag_block_a: assert property (msg_start && msg_rt == 5'h1F && rt_address != 5'h1F && broadcast_invalidate
      |=> !msg_accept) else $error("blocked broadcast accepted");
   accept_idle_a: assert property (msg_accept |-> !$past(msg_cfg_valid))
      else $error("command taken mid message");
   cfg_lat_a: assert property (msg_accept && !soft_reset ##1 !soft_reset |=> msg_cfg_valid)
      else $error("config not valid two cycles after accept");
   cfg_stable_a: assert property (msg_cfg_valid && $past(msg_cfg_valid) |-> $stable(msg_mode) && $stable(msg_buffer_b))
      else $error("mode or buffer moved within message");
   cfg_drop_a: assert property (msg_cfg_valid && msg_end |=> !msg_cfg_valid)
      else $error("config held past message end");
   soft_abort_a: assert property (soft_reset |=> !msg_cfg_valid)
      else $error("message survived soft reset");
   irq_cause_a: assert property (interrupt_out |-> $past(msg_end && (irq_broadcast_flag_enable || irq_access_enable)))
      else $error("interrupt without enabled completion");
   cover property (msg_accept && $past(msg_rt) == 5'h1F);
   cover property (interrupt_out);
   cover property ($rose(msg_buffer_b));
endmodule // rsb_ctrl_monitor
bind rsb_ctrl rsb_ctrl_monitor rsb_ctrl_monitor_inst (.core_clk, .nrst, .soft_reset, .terminal_enable,
   .broadcast_invalidate, .irq_broadcast_flag_enable, .irq_access_enable, .rt_address, .msg_start, .msg_rt, .msg_end,
   .msg_accept, .msg_cfg_valid, .msg_mode, .msg_buffer_b, .interrupt_out);

// ---- test/rsb_host_model.sv ----
`timescale 1ns/10ps
module rsb_host_model (
   input  wire        core_clk,  // Core clock
   output reg         host_wr,   // Write strobe
   output reg         host_rd,   // Read strobe
   output reg  [4:0]  host_sa,   // Subaddress
   output reg  [15:0] host_wdata // Write data
);
   initial begin
      host_wr = 1'b0;
      host_rd = 1'b0;
      host_sa = 5'h00;
      host_wdata = 16'h0000;
   end
   // Whole words only, mode bits and zero count set before use, enable only with terminal on
   task automatic strobe(input logic w, input logic [4:0] sa, input logic [15:0] d);
      begin
         // Random gap: the block sees prompt and slow hosts alike
         repeat ($urandom_range(2)) @(posedge core_clk);
         @(posedge core_clk);
         #1;
         host_wr = w;
         host_rd = ~w;
         host_sa = sa;
         host_wdata = d;
         @(posedge core_clk);
         #1;
         host_wr = 1'b0;
         host_rd = 1'b0;
         // Released lines show the inverse, not a stale value
         host_sa = ~sa;
         host_wdata = ~d;
      end
   endtask
endmodule // rsb_host_model

// ---- test/tb.sv ----
`timescale 1ns/10ps
module tb;
   logic        core_clk, nrst, soft_reset, terminal_enable, broadcast_invalidate, irq_broadcast_flag_enable;
   logic        irq_access_enable, msg_start, msg_end, msg_ok, msg_busy_global, host_wr, host_rd, host_rvalid;
   logic        msg_accept, msg_cfg_valid, msg_buffer_b, msg_store_off, interrupt_out, cfg_d;
   logic [4:0]  rt_address, msg_rt, msg_sa, host_sa;
   logic [1:0]  msg_mode;
   logic [15:0] host_wdata, host_rdata, ew [32], rq [$];
   logic [3:0]  cq [$];
   int          n_fail, n_compared, cyc;
   rsb_ctrl rsb_ctrl_inst (.core_clk, .nrst, .soft_reset, .terminal_enable, .broadcast_invalidate,
      .irq_broadcast_flag_enable, .irq_access_enable, .rt_address, .host_wr, .host_rd, .host_sa, .host_wdata, .host_rdata,
      .host_rvalid, .msg_start, .msg_rt, .msg_sa, .msg_end, .msg_ok, .msg_busy_global, .msg_accept,
      .msg_cfg_valid, .msg_mode, .msg_buffer_b, .msg_store_off, .interrupt_out);
   rsb_host_model rsb_host_model_inst (.core_clk, .host_wr, .host_rd, .host_sa, .host_wdata);
   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end
   task tally_and_finish;
      begin
         $display("compared %0d mismatches %0d", n_compared, n_fail);
         if (n_fail == 0 && n_compared > 0)
            $display("Test passed");
         else
            $display("Test failed");
         $finish;
      end
   endtask
   task chk_word(input logic [15:0] e, g);
      begin
         n_compared++;
         if (e !== g) begin
            n_fail++;
            $display("mismatch t=%0t exp=%h got=%h", $time, e, g);
         end
      end
   endtask
   task chk_cfg(input logic [3:0] e, g);
      chk_word({12'h000, e}, {12'h000, g});
   endtask
   task chk_flag(input logic e, g);
      chk_word({15'h0000, e}, {15'h0000, g});
   endtask
   task wrh(input logic [4:0] sa, input logic [15:0] d);
      begin
         rsb_host_model_inst.strobe(1'b1, sa, d);
         ew[sa] = (d & 16'hF0FF) | (ew[sa] & 16'h0E00);
         ew[sa][8] = d[2] & ~d[3];
         repeat (2) @(posedge core_clk);
         #1;
      end
   endtask
   task rd(input logic [4:0] sa);
      begin
         rq.push_back(ew[sa]);
         rsb_host_model_inst.strobe(1'b0, sa, 16'hFFFF);
         ew[sa][11] = 1'b0;
         repeat (3) @(posedge core_clk);
         #1;
      end
   endtask
   task msg(input logic [4:0] rt, sa, input logic ok, bg);
      logic        acc, bc, irq;
      logic [1:0]  m;
      logic [15:0] w;
      begin
         w = ew[sa];
         acc = terminal_enable && (rt == rt_address || (rt == 5'h1F && !broadcast_invalidate));
         bc = rt == 5'h1F && rt != rt_address;
         m = w[2] ? 2'h3 : w[1] ? 2'h2 : {1'b0, w[0]};
         irq = acc && ((w[14] && irq_access_enable) || (bc && w[13] && irq_broadcast_flag_enable));
         msg_start = 1'b1;
         msg_rt = rt;
         msg_sa = sa;
         msg_ok = ok;
         msg_busy_global = bg;
         @(posedge core_clk);
         #1;
         msg_start = 1'b0;
         // Accept and interrupt are one-cycle pulses: look right after the edge that raises them
         chk_flag(acc, msg_accept);
         if (acc) begin
            cq.push_back({m, w[10] & (m == 2'h3), w[12] | bg});
            repeat (3) @(posedge core_clk);
            #1;
            msg_end = 1'b1;
            @(posedge core_clk);
            #1;
            msg_end = 1'b0;
            chk_flag(irq, interrupt_out);
            ew[sa][9] = w[9] | bc;
            ew[sa][11] = 1'b1;
            if (m == 2'h3 && w[8] && ok && !(w[12] | bg))
               ew[sa][10] = ~w[10];
         end
         repeat (2) @(posedge core_clk);
         #1;
      end
   endtask
   always @(posedge core_clk) begin
      cfg_d <= msg_cfg_valid;
      if (host_rvalid === 1'b1)
         chk_word(rq.pop_front(), host_rdata);
      if (msg_cfg_valid === 1'b1 && cfg_d !== 1'b1)
         chk_cfg(cq.pop_front(), {msg_mode, msg_buffer_b & (msg_mode == 2'h3), msg_store_off});
      cyc++;
      if (cyc == 5000) begin
         n_fail++;
         tally_and_finish;
      end
   end
   initial begin
      void'($urandom(32'h701464EF));
      {nrst, soft_reset, broadcast_invalidate, irq_broadcast_flag_enable, irq_access_enable} = 5'h00;
      {msg_start, msg_end, msg_ok, msg_busy_global, msg_rt, msg_sa} = 14'h0000;
      terminal_enable = 1'b1;
      rt_address = 5'($urandom_range(30));
      foreach (ew[i]) ew[i] = 16'h0000;
      repeat (10) @(posedge core_clk);
      #1;
      nrst = 1'b1;
      for (int i = 0; i < 3; i++) rd(5'($urandom_range(31)));
      for (int i = 0; i < 6; i++) begin
         wrh(5'(i), 16'($urandom));
         rd(5'(i));
      end
      for (int m = 0; m < 8; m++) begin
         irq_access_enable = 1'($urandom_range(1));
         wrh(5'h07, 16'h4000 | 16'(m));
         msg(rt_address, 5'h07, 1'b1, 1'b0);
      end
      wrh(5'h09, 16'h0004);
      rd(5'h09);
      for (int k = 0; k < 2; k++) msg(rt_address, 5'h09, 1'b1, 1'b0);
      msg(rt_address, 5'h09, 1'b0, 1'b0);
      msg(rt_address, 5'h09, 1'b1, 1'b1);
      wrh(5'h09, 16'h000C);
      rd(5'h09);
      msg(rt_address, 5'h09, 1'b1, 1'b0);
      wrh(5'h09, 16'h0004);
      rd(5'h09);
      msg(rt_address, 5'h09, 1'b1, 1'b0);
      wrh(5'h0C, 16'h2000);
      irq_broadcast_flag_enable = 1'b1;
      irq_access_enable = 1'b0;
      msg(5'h1F, 5'h0C, 1'b1, 1'b0);
      rd(5'h0C);
      broadcast_invalidate = 1'b1;
      msg(5'h1F, 5'h0C, 1'b1, 1'b0);
      rd(5'h0C);
      broadcast_invalidate = 1'b0;
      irq_broadcast_flag_enable = 1'b0;
      msg(5'h1F, 5'h0C, 1'b1, 1'b0);
      terminal_enable = 1'b0;
      msg(rt_address, 5'h0C, 1'b1, 1'b0);
      terminal_enable = 1'b1;
      soft_reset = 1'b1;
      @(posedge core_clk);
      #1;
      soft_reset = 1'b0;
      foreach (ew[i]) ew[i] = ew[i] & 16'hF1FF;
      rd(5'h0C);
      rd(5'h09);
      tally_and_finish;
   end
endmodule // tb
